// ===== design/meas_setup.sv
// measuring-time counters, scan sequencer and device settings behind an apb slave
//
// Operation
// - continuous scan samples every active channel equally in strict rotation
// - semi-continuous scan puts the selected channel on every second conversion
// - with clear-at-start on, elapsed run time zeroes at each run start
// - nonzero run length limit stops the run when elapsed time reaches it
// - timer channel counts whole seconds, or tenths when exponent is minus one
// - timer channel wraps to zero at sixty thousand and keeps counting
// - limit-violation actions may start, stop, output or zero the timer channel
// - time and date taken as six digits, held in battery-backed calendar; here plain registers, zeroed at reset and never advanced
// - serial rate defaults to 9600 baud
// - serial rate offers 150 to 9600 baud plus 57.6 and 115.2 kbaud
// - chosen serial rate is written to storage on the interface module
// - serial frame is fixed at eight data bits, one stop, no parity
// - answer only commands that carry this station's own number
// - display brightness has ten steps from 10 to 100 percent
// - global alarm deadband 0 to 99 digits, default 10
// - sensor feed level offers about 6, 9 or 12 volts
// - menu language offers German, English and French
// - sockets own ten ports each; internal socket uses ports 0, 1, 6, 7
// - attached output modules are detected and listed automatically
//
// The address map and the APB slave port are this design's own decisions.
`default_nettype none
module meas_setup
  import meas_setup_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_done,
  input wire logic limit_start,
  input wire logic limit_stop,
  input wire logic limit_output,
  input wire logic limit_zero,
  input wire logic [6:0] cmd_station,
  input wire logic cmd_valid,
  input wire logic [2:0] module_present,
  output logic [2:0] scan_channel,
  output logic run_active,
  output logic cmd_accept,
  output logic timer_out_strobe,
  output logic [15:0] timer_out_value,
  output logic speed_store,
  output logic [3:0] serial_speed_select,
  output logic [1:0] frame_format
);

  typedef struct packed {
    logic running;
    logic clear_at_start;
    logic continuous;
    logic [7:0] chan_mask;
    logic [2:0] selected;
    logic [2:0] scan_ptr;
    logic [2:0] scan_out;
    scan_phase_t phase;
    logic [19:0] tick_div;
    logic [3:0] tenth_cnt;
    logic [16:0] elapsed_run_time;
    logic [16:0] run_length_limit;
    logic [23:0] clock_time_entry;
    logic [23:0] calendar_entry;
    logic [3:0] serial_speed_select;
    logic speed_store;
    logic [6:0] network_station_number;
    logic [3:0] display_brightness_step;
    logic [6:0] alarm_deadband;
    logic [1:0] sensor_feed_level;
    logic [1:0] menu_language_choice;
    logic timer_run;
    logic timer_tenths;
    logic [15:0] timer_count;
    logic [3:0] timer_sub;
    logic timer_out_strobe;
    logic [15:0] timer_out_value;
    logic cmd_accept;
    logic [2:0] mod_s1;
    logic [2:0] mod_s2;
    logic [31:0] prdata;
  } state_t;

  state_t q;
  state_t n;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [2:0] next_active(input logic [7:0] mask, input logic [2:0] from,
                                             input logic [2:0] skip, input logic use_skip);
    logic [2:0] cand;
    logic [2:0] pick;
    logic found;
    cand = from;
    pick = from;
    found = 1'b0;
    for (int i = 1; i <= 8; i++) begin
      cand = 3'(from + 3'(i));
      if (!found && mask[cand] && !(use_skip && cand == skip)) begin
        pick = cand;
        found = 1'b1;
      end
    end
    if (!found) begin
      pick = skip;
    end
    return pick;
  endfunction

  function automatic logic [16:0] hms_to_sec(input logic [23:0] hms);
    return 17'(hms[23:16]) * 17'd3600 + 17'(hms[15:8]) * 17'd60 + 17'(hms[7:0]);
  endfunction

  function automatic logic valid_speed(input logic [3:0] s);
    return s <= SPEED_115200;
  endfunction

  // ------------------------------------------------------------------
  // apb access decode and control write pulses
  // ------------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic sec_tick;
  logic run_start;
  logic run_stop;
  logic [31:0] ctrl_w;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  // partial strobes must not fire the control pulses either
  assign ctrl_w = (wr_en && pstrb == 4'hf && paddr == CTRL_ADDR) ? pwdata : 32'h0000_0000;
  assign run_start = ctrl_w[CTRL_START_BIT] && !q.running;
  assign run_stop = ctrl_w[CTRL_STOP_BIT];

  always_comb begin
    n = q;
    n.speed_store = 1'b0;
    n.timer_out_strobe = 1'b0;
    n.cmd_accept = 1'b0;
    n.mod_s1 = module_present;
    n.mod_s2 = q.mod_s1;
    sec_tick = 1'b0;

    // ----------------------------------------------------------------
    // tenth-second divider; seconds from ten tenths
    // ----------------------------------------------------------------
    if (q.tick_div == 20'(TENTH_CYCLES - 1)) begin
      n.tick_div = 20'h00000;
      if (q.tenth_cnt == 4'(TENTHS_PER_SEC - 1)) begin
        n.tenth_cnt = 4'h0;
        sec_tick = 1'b1;
      end else begin
        n.tenth_cnt = q.tenth_cnt + 4'h1;
      end
    end else begin
      n.tick_div = q.tick_div + 20'h00001;
    end
    // the timer channel uses its own tenth count so seconds mode is exact
    if (q.tick_div == 20'(TENTH_CYCLES - 1) && q.timer_run) begin
      if (q.timer_tenths || q.timer_sub == 4'(TENTHS_PER_SEC - 1)) begin
        n.timer_sub = 4'h0;
        if (q.timer_count == TIMER_WRAP - 16'h0001) begin
          n.timer_count = 16'h0000;
        end else begin
          n.timer_count = q.timer_count + 16'h0001;
        end
      end else begin
        n.timer_sub = q.timer_sub + 4'h1;
      end
    end

    // ----------------------------------------------------------------
    // run control and elapsed run time
    // ----------------------------------------------------------------
    if (run_start) begin
      n.running = 1'b1;
      if (q.clear_at_start) begin
        n.elapsed_run_time = 17'h00000;
      end
    end else if (run_stop) begin
      n.running = 1'b0;
    end else if (q.running && sec_tick) begin
      n.elapsed_run_time = q.elapsed_run_time + 17'h00001;
      if (q.run_length_limit != 17'h00000
          && q.elapsed_run_time + 17'h00001 >= q.run_length_limit) begin
        n.running = 1'b0;
      end
    end
    if (ctrl_w[CTRL_CLEAR_RUN_TIME_BIT]) begin
      n.elapsed_run_time = 17'h00000;
    end

    // ----------------------------------------------------------------
    // timer channel start, stop, zero, output (keys or limit events)
    // ----------------------------------------------------------------
    if (ctrl_w[CTRL_TIMER_START_BIT] || limit_start) begin
      n.timer_run = 1'b1;
    end
    if (ctrl_w[CTRL_TIMER_STOP_BIT] || limit_stop) begin
      n.timer_run = 1'b0;
    end
    if (ctrl_w[CTRL_TIMER_ZERO_BIT] || limit_zero) begin
      n.timer_count = 16'h0000;
      n.timer_sub = 4'h0;
    end
    if (ctrl_w[CTRL_TIMER_OUT_BIT] || limit_output) begin
      n.timer_out_strobe = 1'b1;
      n.timer_out_value = q.timer_count;
    end

    // ----------------------------------------------------------------
    // scan sequencer, advanced on each finished conversion
    // ----------------------------------------------------------------
    if (conv_done) begin
      if (q.continuous) begin
        n.scan_out = next_active(q.chan_mask, q.scan_out, q.scan_out, 1'b0);
      end else if (q.phase == SCAN_PREFERRED) begin
        // leaving the preferred slot: visit the next other channel
        n.scan_ptr = next_active(q.chan_mask, q.scan_ptr, q.selected, 1'b1);
        n.scan_out = n.scan_ptr;
        n.phase = SCAN_OTHER;
      end else begin
        n.scan_out = q.selected;
        n.phase = SCAN_PREFERRED;
      end
    end

    // ----------------------------------------------------------------
    // station number match
    // ----------------------------------------------------------------
    if (cmd_valid && cmd_station == q.network_station_number) begin
      n.cmd_accept = 1'b1;
    end

    // ----------------------------------------------------------------
    // register writes; out-of-range speed, station and settings values are ignored; run limit is converted to seconds, time and date are taken as written
    // ----------------------------------------------------------------
    if (wr_en && pstrb == 4'hf) begin
      case (paddr)
        CTRL_ADDR: begin
          n.clear_at_start = pwdata[CTRL_CLEAR_AT_START_BIT];
          n.continuous = pwdata[CTRL_CONTINUOUS_BIT];
          n.timer_tenths = pwdata[CTRL_TIMER_TENTHS_BIT];
        end
        RUN_LIMIT_ADDR: begin
          n.run_length_limit = hms_to_sec(pwdata[23:0]);
        end
        CLOCK_TIME_ADDR: begin
          n.clock_time_entry = pwdata[23:0];
        end
        CALENDAR_ADDR: begin
          n.calendar_entry = pwdata[23:0];
        end
        SERIAL_ADDR: begin
          if (valid_speed(pwdata[3:0])) begin
            n.serial_speed_select = pwdata[3:0];
            n.speed_store = 1'b1;
          end
        end
        STATION_ADDR: begin
          if (pwdata[6:0] <= STATION_MAX) begin
            n.network_station_number = pwdata[6:0];
          end
        end
        SETTINGS_ADDR: begin
          if (pwdata[3:0] <= BRIGHT_MAX) begin
            n.display_brightness_step = pwdata[3:0];
          end
          if (pwdata[14:8] <= DEADBAND_MAX) begin
            n.alarm_deadband = pwdata[14:8];
          end
          if (pwdata[17:16] != 2'h3) begin
            n.sensor_feed_level = pwdata[17:16];
          end
          if (pwdata[25:24] != 2'h3) begin
            n.menu_language_choice = pwdata[25:24];
          end
        end
        SCAN_ADDR: begin
          n.chan_mask = pwdata[7:0];
          n.selected = pwdata[10:8];
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // register reads, captured in the setup cycle
    // ----------------------------------------------------------------
    if (rd_en) begin
      case (paddr)
        CTRL_ADDR: n.prdata = {22'h000000, 1'b0, q.timer_tenths, 3'h0, q.continuous, 1'b0,
                               q.clear_at_start, 2'h0};
        STATUS_ADDR: n.prdata = {28'h0000000, q.timer_run, q.phase == SCAN_OTHER,
                                 q.continuous, q.running};
        RUN_TIME_ADDR: n.prdata = {15'h0000, q.elapsed_run_time};
        RUN_LIMIT_ADDR: n.prdata = {15'h0000, q.run_length_limit};
        CLOCK_TIME_ADDR: n.prdata = {8'h00, q.clock_time_entry};
        CALENDAR_ADDR: n.prdata = {8'h00, q.calendar_entry};
        SERIAL_ADDR: n.prdata = {28'h0000000, q.serial_speed_select};
        STATION_ADDR: n.prdata = {25'h0000000, q.network_station_number};
        SETTINGS_ADDR: n.prdata = {6'h00, q.menu_language_choice, 6'h00, q.sensor_feed_level,
                                   1'b0, q.alarm_deadband, 4'h0, q.display_brightness_step};
        TIMER_ADDR: n.prdata = {16'h0000, q.timer_count};
        SCAN_ADDR: n.prdata = {21'h000000, q.selected, q.chan_mask};
        MATCH_ADDR: n.prdata = {29'h00000000, q.scan_out};
        PORT_MAP_ADDR: n.prdata = {11'h000, SOCKET3_BASE, 3'h0, SOCKET2_BASE,
                                   PORT_MAP_INTERNAL};
        MODULES_ADDR: n.prdata = {29'h00000000, q.mod_s2};
        default: n.prdata = UNMAPPED_DATA;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.chan_mask <= CHAN_MASK_DEFAULT;
      q.phase <= SCAN_PREFERRED;
      q.serial_speed_select <= SPEED_9600;
      q.network_station_number <= STATION_DEFAULT;
      q.display_brightness_step <= BRIGHT_DEFAULT;
      q.alarm_deadband <= DEADBAND_DEFAULT;
      q.sensor_feed_level <= FEED_DEFAULT;
      q.menu_language_choice <= LANG_DEFAULT;
    end else begin
      q <= n;
    end
  end

  // ------------------------------------------------------------------
  // outputs; slave always answers in the first access cycle
  // ------------------------------------------------------------------
  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign scan_channel = q.scan_out;
  assign run_active = q.running;
  assign cmd_accept = q.cmd_accept;
  assign timer_out_strobe = q.timer_out_strobe;
  assign timer_out_value = q.timer_out_value;
  assign speed_store = q.speed_store;
  assign serial_speed_select = q.serial_speed_select;
  assign frame_format = 2'h0;

endmodule
`default_nettype wire

// ===== inc/meas_setup_pkg.sv
// constants, register map and types for the measuring-time and device setup block
`default_nettype none
package meas_setup_pkg;
  // ------------------------------------------------------------------
  // clock and time bases
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TENTH_MS = 100;
  localparam int unsigned TENTH_CYCLES = CLK_HZ / 1000 * TENTH_MS;
  localparam int unsigned TENTHS_PER_SEC = 10;
  localparam logic [15:0] TIMER_WRAP = 16'hea60;
  localparam int unsigned CONV_RATE_DEFAULT_HZ = 10;

  // ------------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] RUN_TIME_ADDR = 8'h08;
  localparam logic [7:0] RUN_LIMIT_ADDR = 8'h0c;
  localparam logic [7:0] CLOCK_TIME_ADDR = 8'h10;
  localparam logic [7:0] CALENDAR_ADDR = 8'h14;
  localparam logic [7:0] SERIAL_ADDR = 8'h18;
  localparam logic [7:0] STATION_ADDR = 8'h1c;
  localparam logic [7:0] SETTINGS_ADDR = 8'h20;
  localparam logic [7:0] TIMER_ADDR = 8'h24;
  localparam logic [7:0] SCAN_ADDR = 8'h28;
  localparam logic [7:0] MATCH_ADDR = 8'h2c;
  localparam logic [7:0] PORT_MAP_ADDR = 8'h30;
  localparam logic [7:0] MODULES_ADDR = 8'h34;

  // ctrl bits
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CTRL_CLEAR_AT_START_BIT = 2;
  localparam int CTRL_CLEAR_RUN_TIME_BIT = 3;
  localparam int CTRL_CONTINUOUS_BIT = 4;
  localparam int CTRL_TIMER_START_BIT = 5;
  localparam int CTRL_TIMER_STOP_BIT = 6;
  localparam int CTRL_TIMER_ZERO_BIT = 7;
  localparam int CTRL_TIMER_TENTHS_BIT = 8;
  localparam int CTRL_TIMER_OUT_BIT = 9;

  // ------------------------------------------------------------------
  // reset values and encodings
  // ------------------------------------------------------------------
  localparam logic [3:0] SPEED_150 = 4'h0;
  localparam logic [3:0] SPEED_9600 = 4'h6;
  localparam logic [3:0] SPEED_115200 = 4'h8;
  localparam logic [6:0] STATION_DEFAULT = 7'h00;
  localparam logic [6:0] STATION_MAX = 7'h63;
  localparam logic [6:0] DEADBAND_DEFAULT = 7'h0a;
  localparam logic [6:0] DEADBAND_MAX = 7'h63;
  localparam logic [3:0] BRIGHT_MAX = 4'h9;
  localparam logic [3:0] BRIGHT_DEFAULT = 4'h9;
  localparam logic [1:0] FEED_DEFAULT = 2'h2;
  localparam logic [1:0] LANG_DEFAULT = 2'h1;
  localparam logic [7:0] CHAN_MASK_DEFAULT = 8'h01;
  localparam logic [7:0] PORT_MAP_INTERNAL = 8'hc3;
  localparam logic [4:0] SOCKET2_BASE = 5'h0a;
  localparam logic [4:0] SOCKET3_BASE = 5'h14;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  typedef enum logic [1:0] {FEED_6V, FEED_9V, FEED_12V} feed_level_t;
  typedef enum logic [1:0] {LANG_GERMAN, LANG_ENGLISH, LANG_FRENCH} menu_lang_t;
  typedef enum {SCAN_PREFERRED, SCAN_OTHER} scan_phase_t;
endpackage
`default_nettype wire

// ===== verification/meas_setup_assertions.sv
// port checker for the measuring-time and setup block
`default_nettype none
module meas_setup_assertions
  import meas_setup_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic conv_done,
  input wire logic limit_output,
  input wire logic cmd_valid,
  input wire logic cmd_accept,
  input wire logic [2:0] scan_channel,
  input wire logic run_active,
  input wire logic timer_out_strobe,
  input wire logic [15:0] timer_out_value,
  input wire logic speed_store,
  input wire logic [3:0] serial_speed_select,
  input wire logic [1:0] frame_format
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // write decode and properties
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic out_req;
  assign wr = psel && penable && pwrite && pstrb == 4'hf;
  assign out_req = limit_output || (wr && paddr == CTRL_ADDR && pwdata[CTRL_TIMER_OUT_BIT]);
  sequence s_ctrl_wr(int b);
    wr && paddr == CTRL_ADDR && pwdata[b];
  endsequence
  sequence s_speed_wr;
    wr && paddr == SERIAL_ADDR && pwdata[31:4] == 28'h0 && pwdata[3:0] <= SPEED_115200;
  endsequence
  property p_frame;
    frame_format == 2'h0;
  endproperty
  property p_speed_range;
    serial_speed_select <= SPEED_115200;
  endproperty
  property p_speed_store;
    s_speed_wr |=> speed_store && serial_speed_select == $past(pwdata[3:0]);
  endproperty
  property p_store_cause;
    speed_store |-> $past(wr) && $past(paddr) == SERIAL_ADDR;
  endproperty
  property p_accept;
    cmd_accept |-> $past(cmd_valid);
  endproperty
  property p_start;
    s_ctrl_wr(CTRL_START_BIT) ##0 !pwdata[CTRL_STOP_BIT] |=> run_active;
  endproperty
  property p_out;
    out_req |=> timer_out_strobe;
  endproperty
  property p_out_cause;
    timer_out_strobe |-> $past(out_req) && timer_out_value < TIMER_WRAP;
  endproperty
  property p_scan;
    !$stable(scan_channel) |-> $past(conv_done) || $past(wr);
  endproperty
  a_frame: assert property (p_frame) else $error("frame format changed");
  a_speed_range: assert property (p_speed_range) else $error("speed code out of range");
  a_speed_store: assert property (p_speed_store) else $error("speed not stored");
  a_store_cause: assert property (p_store_cause) else $error("stray speed store");
  a_accept: assert property (p_accept) else $error("accept without command");
  a_start: assert property (p_start) else $error("run did not start");
  a_out: assert property (p_out) else $error("timer output missing");
  a_out_cause: assert property (p_out_cause) else $error("bad timer output");
  a_scan: assert property (p_scan) else $error("scan moved without cause");
endmodule
bind meas_setup meas_setup_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .conv_done, .limit_output, .cmd_valid, .cmd_accept, .scan_channel,
  .run_active, .timer_out_strobe, .timer_out_value, .speed_store, .serial_speed_select,
  .frame_format);
`default_nettype wire

// ===== verification/host_link_model.sv
// host model issuing station-addressed commands
`default_nettype none
module host_link_model (
  input wire logic pclk,
  input wire logic cmd_accept,
  output logic [6:0] cmd_station,
  output logic cmd_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_station = 7'h00;
    cmd_valid = 1'b0;
  end
  // one station number per command; gap gives a slow host
  task automatic send(input logic [6:0] num, input int gap, output logic acc);
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    cmd_station <= num;
    cmd_valid <= 1'b1;
    @(posedge pclk);
    cmd_valid <= 1'b0;
    // number is not held after the pulse
    cmd_station <= ~num;
    #1;
    acc = cmd_accept;
  endtask
endmodule
`default_nettype wire

// ===== verification/tb_meas_setup.sv
// self-checking bench for the measuring-time and setup block
`default_nettype none
module tb_meas_setup
  import meas_setup_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic conv_done = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [3:0] lim = 4'h0;
  logic [2:0] module_present = 3'b101;
  logic [31:0] prdata;
  logic pready, pslverr, cmd_accept, cmd_valid, run_active, timer_out_strobe, speed_store;
  logic [6:0] cmd_station;
  logic [2:0] scan_channel;
  logic [15:0] timer_out_value;
  logic [3:0] serial_speed_select;
  logic [1:0] frame_format;
  logic [31:0] rd;
  logic acc;
  int fail_count = 0;
  int checked = 0;
  int cnt [8];
  int same, ev;
  always #50 pclk = ~pclk;
  meas_setup u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .conv_done, .limit_start(lim[0]), .limit_stop(lim[1]),
    .limit_output(lim[2]), .limit_zero(lim[3]), .cmd_station, .cmd_valid, .module_present,
    .scan_channel, .run_active, .cmd_accept, .timer_out_strobe, .timer_out_value,
    .speed_store, .serial_speed_select, .frame_format);
  host_link_model u_host (.pclk, .cmd_accept, .cmd_station, .cmd_valid);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rd);
    chk(rd, e);
  endtask
  task automatic lim_pulse(input logic [3:0] v);
    @(posedge pclk);
    lim <= v;
    @(posedge pclk);
    lim <= 4'h0;
    #1;
    chk(32'(timer_out_strobe), 32'(v[2]));
  endtask
  task automatic run_scan(input int n);
    cnt = '{default: 0};
    same = 0;
    ev = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      conv_done <= 1'b1;
      @(posedge pclk);
      conv_done <= 1'b0;
      #1;
      cnt[scan_channel]++;
      if (i > 0 && scan_channel == rd[2:0]) same++;
      if (i % 2 == 0 && scan_channel == 3'd2) ev++;
      rd = 32'(scan_channel);
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_settings();
    rdchk(SERIAL_ADDR, 32'h6);
    rdchk(SETTINGS_ADDR, 32'h0102_0a09);
    rdchk(PORT_MAP_ADDR, 32'h0014_0ac3);
    rdchk(MODULES_ADDR, 32'h5);
    module_present <= 3'b011;
    repeat (3) @(posedge pclk);
    rdchk(MODULES_ADDR, 32'h3);
    rdchk(8'h3c, 32'h0);
    wr(SETTINGS_ADDR, 32'h0000_6300);
    rdchk(SETTINGS_ADDR, 32'h0000_6300);
    wr(SETTINGS_ADDR, 32'h0303_640a);
    rdchk(SETTINGS_ADDR, 32'h0000_6300);
    wr(SETTINGS_ADDR, 32'h0201_0009);
    rdchk(SETTINGS_ADDR, 32'h0201_0009);
    chk(32'(frame_format), 32'h0);
    for (int i = 0; i < 10; i++) begin
      wr(SERIAL_ADDR, 32'(i));
      #1;
      chk(32'(speed_store), 32'(i < 9));
      chk(32'(serial_speed_select), 32'(i < 9 ? i : 8));
    end
    pstrb <= 4'h1;
    wr(SERIAL_ADDR, 32'h3);
    pstrb <= 4'hf;
    #1;
    chk(32'(speed_store), 32'h0);
    chk(32'(serial_speed_select), 32'h8);
    $display("test settings done");
  endtask
  task automatic t_station();
    u_host.send(7'h00, 0, acc);
    chk(32'(acc), 32'h1);
    wr(STATION_ADDR, 32'h63);
    u_host.send(7'h63, 0, acc);
    chk(32'(acc), 32'h1);
    u_host.send(7'h05, 3, acc);
    chk(32'(acc), 32'h0);
    wr(STATION_ADDR, 32'h64);
    rdchk(STATION_ADDR, 32'h63);
    u_host.send(7'h00, 0, acc);
    chk(32'(acc), 32'h0);
    wr(CLOCK_TIME_ADDR, 32'h000c_2238);
    rdchk(CLOCK_TIME_ADDR, 32'h000c_2238);
    wr(CALENDAR_ADDR, 32'h0001_0208);
    rdchk(CALENDAR_ADDR, 32'h0001_0208);
    $display("test station done");
  endtask
  task automatic t_run();
    wr(RUN_LIMIT_ADDR, 32'h0001_1e00);
    rdchk(RUN_LIMIT_ADDR, 32'd5400);
    pstrb <= 4'h1;
    wr(CTRL_ADDR, 32'h1);
    pstrb <= 4'hf;
    #1;
    chk(32'(run_active), 32'h0);
    wr(CTRL_ADDR, 32'h5);
    #1;
    chk(32'(run_active), 32'h1);
    rdchk(RUN_TIME_ADDR, 32'h0);
    rdchk(CTRL_ADDR, 32'h4);
    apb(1'b0, STATUS_ADDR, 32'h0, rd);
    chk(rd & 32'h1, 32'h1);
    wr(CTRL_ADDR, 32'h6);
    #1;
    chk(32'(run_active), 32'h0);
    $display("test run done");
  endtask
  task automatic t_timer();
    lim_pulse(4'b0001);
    apb(1'b0, STATUS_ADDR, 32'h0, rd);
    chk(rd & 32'h8, 32'h8);
    lim_pulse(4'b0010);
    apb(1'b0, STATUS_ADDR, 32'h0, rd);
    chk(rd & 32'h8, 32'h0);
    lim_pulse(4'b1000);
    rdchk(TIMER_ADDR, 32'h0);
    lim_pulse(4'b0100);
    chk(32'(timer_out_value), 32'h0);
    wr(CTRL_ADDR, 32'h300);
    #1;
    chk(32'(timer_out_strobe), 32'h1);
    rdchk(CTRL_ADDR, 32'h100);
    $display("test timer done");
  endtask
  task automatic t_scan();
    wr(SCAN_ADDR, 32'h0000_020d);
    rdchk(SCAN_ADDR, 32'h0000_020d);
    run_scan(8);
    chk(32'(cnt[2]), 32'd4);
    chk(32'(ev * (4 - ev)), 32'd0);
    chk(32'(cnt[0] + 10 * cnt[3]), 32'd22);
    wr(CTRL_ADDR, 32'h10);
    run_scan(6);
    chk(32'(cnt[0] + 10 * cnt[2] + 100 * cnt[3]), 32'd222);
    chk(32'(same), 32'd0);
    $display("test scan done");
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_settings();
    t_station();
    t_run();
    t_timer();
    t_scan();
    end_sim();
  end
endmodule
`default_nettype wire
